// *** src/prd_pkg.sv ***
/*
  Shared constants for the pipelined request decoder: command codes, length
  field layout, unit sizes and the decoder state encoding.
  Assumes one clock domain and command codes already in true (active-high) form.
*/
package prd_pkg;

  // Command codes
  localparam logic [3:0] CMD_READ = 4'h0;
  localparam logic [3:0] CMD_READ_URG = 4'h1;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_WRITE_URG = 4'h5;
  localparam logic [3:0] CMD_LREAD = 4'h8;
  localparam logic [3:0] CMD_LREAD_URG = 4'h9;
  localparam logic [3:0] CMD_FLUSH = 4'hA;
  localparam logic [3:0] CMD_FENCE = 4'hC;
  localparam logic [3:0] CMD_DAC = 4'hD;

  ////////////////////////////////////////////////////////////////////////////
  // Request layout
  localparam int LEN_LSB = 0;
  localparam int LEN_W = 3;
  localparam int UNIT_BYTES = 8;
  localparam int UNITS_W = 6;
  localparam logic [5:0] LONG_FACTOR = 6'h04;
  localparam logic [5:0] FLUSH_UNITS = 6'h01;
  localparam logic [5:0] FENCE_UNITS = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Decoder states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_DAC_HI = 1'b1
  } prd_state_e;

endpackage : prd_pkg

// *** src/prd_cmd_decode.sv ***
/*
  Combinational decode of one 4-bit command code into request classes.
  Assumes the caller says whether the code arrived where a dual address
  cycle code is not valid (sideband port, or the second clock of a DAC).
*/
module prd_cmd_decode
  import prd_pkg::*;
(
  input wire logic [3:0] i_command_code,
  input wire logic i_dac_illegal,
  output logic o_read,
  output logic o_write,
  output logic o_urgent,
  output logic o_long,
  output logic o_flush,
  output logic o_fence,
  output logic o_dac,
  output logic o_reserved
);

  always_comb
  begin
    o_read = 1'b0;
    o_write = 1'b0;
    o_urgent = 1'b0;
    o_long = 1'b0;
    o_flush = 1'b0;
    o_fence = 1'b0;
    o_dac = 1'b0;
    o_reserved = 1'b0;
    case (i_command_code)
      CMD_READ: o_read = 1'b1;
      CMD_READ_URG:
      begin
        o_read = 1'b1;
        o_urgent = 1'b1;
      end
      CMD_WRITE: o_write = 1'b1;
      CMD_WRITE_URG:
      begin
        o_write = 1'b1;
        o_urgent = 1'b1;
      end
      CMD_LREAD:
      begin
        o_read = 1'b1;
        o_long = 1'b1;
      end
      CMD_LREAD_URG:
      begin
        o_read = 1'b1;
        o_long = 1'b1;
        o_urgent = 1'b1;
      end
      CMD_FLUSH: o_flush = 1'b1;
      CMD_FENCE: o_fence = 1'b1;
      CMD_DAC:
      begin
        // Sideband or nested DAC is treated as reserved
        o_dac = ~i_dac_illegal;
        o_reserved = i_dac_illegal;
      end
      default: o_reserved = 1'b1;
    endcase
  end

endmodule // prd_cmd_decode

// *** src/prd_decoder.sv ***
/*
  Pipelined request decoder: takes requests from the multiplexed bus or the
  sideband port, assembles dual address cycles, decodes command and length,
  and emits one registered request per accepted command with stream ordering
  marks for the memory side. Reserved codes are dropped and counted.
  Assumes a single clock, requests synchronous to it, and one enqueue mode
  selected by i_use_sideband at a time.
*/
module prd_decoder
  import prd_pkg::*;
#(
  parameter int SEQ_W = 8,
  parameter int SLOTS = 256,
  parameter int CNT_W = 8
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_use_sideband,
  input wire logic i_ad_req,
  input wire logic [31:0] i_ad_addr,
  input wire logic [3:0] i_ad_cmd,
  input wire logic i_sb_req,
  input wire logic [31:0] i_sb_addr,
  input wire logic [3:0] i_sb_cmd,
  input wire logic i_sb_hi_req,
  input wire logic [31:0] i_sb_hi_addr,
  input wire logic i_slot_free,
  input wire logic i_diag_clear,
  output logic o_req_valid,
  output logic [63:0] o_req_addr,
  output logic [UNITS_W-1:0] o_req_units,
  output logic o_req_write,
  output logic o_req_urgent,
  output logic o_req_long,
  output logic o_req_flush,
  output logic o_req_fence,
  output logic [SEQ_W-1:0] o_req_seq,
  output logic [SEQ_W-1:0] o_req_wr_mark,
  output logic [SEQ_W-1:0] o_req_rd_mark,
  output logic [8:0] o_slots_used,
  output logic o_slot_overflow,
  output logic o_reserved_seen,
  output logic [CNT_W-1:0] o_reserved_count
);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Request source selection

  prd_state_e state_ff;
  prd_state_e nxt_state;
  logic [31:0] lo_addr_ff;
  logic [31:0] sb_upper_ff;
  logic take;
  logic [3:0] cmd_in;
  logic [31:0] addr_in;
  logic [31:0] lo_word;
  logic [31:0] hi_word;
  logic [LEN_W-1:0] len_code;
  logic d_read, d_write, d_urgent, d_long, d_flush, d_fence, d_dac, d_reserved;
  logic accept;
  logic dac_first;
  logic reserved_take;

  // Only pipelined requests enter; PCI cycles keep their own ordering outside
  assign take = i_use_sideband ? i_sb_req : i_ad_req;
  assign cmd_in = i_use_sideband ? i_sb_cmd : i_ad_cmd;
  assign addr_in = i_use_sideband ? i_sb_addr : i_ad_addr;
  // Second DAC clock carries the high word; low word was latched in the first
  assign lo_word = (state_ff == ST_DAC_HI) ? lo_addr_ff : addr_in;
  assign hi_word = i_use_sideband ? sb_upper_ff :
                   ((state_ff == ST_DAC_HI) ? i_ad_addr : 32'h0000_0000);
  assign len_code = lo_word[LEN_LSB +: LEN_W];

  prd_cmd_decode u_dec (
    .i_command_code(cmd_in),
    .i_dac_illegal(i_use_sideband || (state_ff == ST_DAC_HI)),
    .o_read(d_read),
    .o_write(d_write),
    .o_urgent(d_urgent),
    .o_long(d_long),
    .o_flush(d_flush),
    .o_fence(d_fence),
    .o_dac(d_dac),
    .o_reserved(d_reserved)
  );

  assign dac_first = take && d_dac;
  assign reserved_take = take && d_reserved;
  assign accept = take && !d_dac && !d_reserved;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (dac_first) nxt_state = ST_DAC_HI;
      ST_DAC_HI: if (take) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      lo_addr_ff <= 32'h0000_0000;
    else if (dac_first)
      lo_addr_ff <= i_ad_addr;
  end

  // Upper address word persists for later sideband requests
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      sb_upper_ff <= 32'h0000_0000;
    else if (i_sb_hi_req)
      sb_upper_ff <= i_sb_hi_addr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stream sequence counters

  // Separate counters per stream give in-order return inside each stream
  // while leaving streams free to complete in any mutual order
  logic [SEQ_W-1:0] nrd_seq_ff;
  logic [SEQ_W-1:0] nwr_seq_ff;
  logic [SEQ_W-1:0] urd_seq_ff;
  logic [SEQ_W-1:0] uwr_seq_ff;
  logic [SEQ_W-1:0] fence_rd_ff;
  logic is_nrd, is_nwr, is_urd, is_uwr;

  // Flush counts as a normal read for return order
  assign is_nrd = accept && ((d_read && !d_urgent) || d_flush);
  assign is_nwr = accept && d_write && !d_urgent;
  assign is_urd = accept && d_read && d_urgent;
  assign is_uwr = accept && d_write && d_urgent;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      nrd_seq_ff <= '0;
      nwr_seq_ff <= '0;
      urd_seq_ff <= '0;
      uwr_seq_ff <= '0;
    end
    else
    begin
      if (is_nrd) nrd_seq_ff <= nrd_seq_ff + 1'b1;
      if (is_nwr) nwr_seq_ff <= nwr_seq_ff + 1'b1;
      if (is_urd) urd_seq_ff <= urd_seq_ff + 1'b1;
      if (is_uwr) uwr_seq_ff <= uwr_seq_ff + 1'b1;
    end
  end

  // Fence snapshots how many normal reads later writes must wait behind
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      fence_rd_ff <= '0;
    else if (accept && d_fence)
      fence_rd_ff <= nrd_seq_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered request output

  logic [UNITS_W-1:0] units;
  logic [UNITS_W-1:0] short_units;

  assign short_units = UNITS_W'(len_code) + 1'b1;
  always_comb
  begin
    if (d_fence)
      units = FENCE_UNITS;
    else if (d_flush)
      units = FLUSH_UNITS;
    else if (d_long)
      units = UNITS_W'(short_units * LONG_FACTOR);
    else
      units = short_units;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_req_valid <= 1'b0;
    else
      o_req_valid <= accept;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_req_addr <= 64'h0000_0000_0000_0000;
      o_req_units <= '0;
      o_req_write <= 1'b0;
      o_req_urgent <= 1'b0;
      o_req_long <= 1'b0;
      o_req_flush <= 1'b0;
      o_req_fence <= 1'b0;
      o_req_seq <= '0;
      o_req_wr_mark <= '0;
      o_req_rd_mark <= '0;
    end
    else if (accept)
    begin
      // Low three bits are the length code, so the address is 8-byte aligned
      o_req_addr <= (d_flush || d_fence) ? 64'h0000_0000_0000_0000 :
                    {hi_word, lo_word[31:3], 3'h0};
      o_req_units <= units;
      o_req_write <= d_write;
      o_req_urgent <= d_urgent;
      o_req_long <= d_long;
      o_req_flush <= d_flush;
      o_req_fence <= d_fence;
      if (is_urd)
        o_req_seq <= urd_seq_ff;
      else if (is_uwr)
        o_req_seq <= uwr_seq_ff;
      else if (is_nwr)
        o_req_seq <= nwr_seq_ff;
      else
        o_req_seq <= nrd_seq_ff;
      // Normal reads and flushes wait for all normal writes before them
      o_req_wr_mark <= nwr_seq_ff;
      // Normal writes may pass reads, but not those before the last fence
      o_req_rd_mark <= d_fence ? nrd_seq_ff : fence_rd_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pipe slot accounting

  logic slot_take;
  assign slot_take = accept && !d_fence;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_slots_used <= 9'h000;
    else if (slot_take && !(i_slot_free && o_slots_used != 9'h000))
      o_slots_used <= o_slots_used + 9'h001;
    else if (!slot_take && i_slot_free && o_slots_used != 9'h000)
      o_slots_used <= o_slots_used - 9'h001;
  end

  // Diagnostic only: master is trusted to respect its allocation
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_slot_overflow <= 1'b0;
    else if (slot_take && !i_slot_free && o_slots_used >= 9'(SLOTS))
      o_slot_overflow <= 1'b1;
    else if (i_diag_clear)
      o_slot_overflow <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reserved code diagnostics; a new event wins over a clear

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_reserved_seen <= 1'b0;
    else if (reserved_take)
      o_reserved_seen <= 1'b1;
    else if (i_diag_clear)
      o_reserved_seen <= 1'b0;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_reserved_count <= '0;
    else if (reserved_take && o_reserved_count != '1)
      o_reserved_count <= o_reserved_count + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_dac_two_clocks: assert property (
    (!i_use_sideband && state_ff == ST_IDLE && i_ad_req && i_ad_cmd == CMD_DAC)
    |=> !o_req_valid && state_ff == ST_DAC_HI)
    else $error("DAC first clock did not wait for high word");

  chk_sb_dac_reserved: assert property (
    (i_use_sideband && i_sb_req && i_sb_cmd == CMD_DAC)
    |=> !o_req_valid && o_reserved_seen && state_ff == ST_IDLE)
    else $error("Sideband DAC code not handled as reserved");

  chk_reserved_dropped: assert property (
    reserved_take |=> !o_req_valid && o_reserved_seen)
    else $error("Reserved code enqueued or not recorded");

  chk_short_units: assert property (
    (o_req_valid && !o_req_long && !o_req_flush && !o_req_fence)
    |-> o_req_units >= 6'h01 && o_req_units <= 6'h08)
    else $error("Short request unit count out of range");

  chk_long_units: assert property (
    (o_req_valid && o_req_long)
    |-> o_req_units[1:0] == 2'h0 && o_req_units >= 6'h04 && o_req_units <= 6'h20)
    else $error("Long read unit count not a multiple of four");

  chk_flush_one_unit: assert property (
    (o_req_valid && o_req_flush) |-> o_req_units == FLUSH_UNITS && o_req_addr == 64'h0)
    else $error("Flush not reduced to one unit");

  chk_fence_no_slot: assert property (
    (o_req_valid && o_req_fence && !$past(i_slot_free))
    |-> o_slots_used == $past(o_slots_used))
    else $error("Fence took a pipe slot");

  chk_read_push_wr: assert property (
    (accept && d_read && !d_urgent) |=> o_req_valid && o_req_wr_mark == nwr_seq_ff)
    else $error("Normal read does not mark all earlier writes");

  chk_sticky_set_wins: assert property (
    (reserved_take && i_diag_clear) |=> o_reserved_seen)
    else $error("Reserved flag lost to simultaneous clear");

endmodule // prd_decoder

// *** dv/prd_master_model.sv ***
/*
  Graphics master model: enqueues requests on the multiplexed bus or the
  sideband port and retires pipe slots.
  Assumes one caller process; every drive lands 1 ns after a rising edge.
*/
module prd_master_model
  import prd_pkg::*;
#(
  parameter int SLOTS = 8
)
(
  input wire logic i_clk,
  output logic o_use_sideband,
  output logic o_ad_req,
  output logic [31:0] o_ad_addr,
  output logic [3:0] o_ad_cmd,
  output logic o_sb_req,
  output logic [31:0] o_sb_addr,
  output logic [3:0] o_sb_cmd,
  output logic o_sb_hi_req,
  output logic [31:0] o_sb_hi_addr,
  output logic o_slot_free
);
  timeunit 1ns;
  timeprecision 1ps;

  int outstanding = 0;
  logic [31:0] hi_cur = 32'h0;

  initial
  begin
    {o_use_sideband, o_ad_req, o_sb_req, o_sb_hi_req, o_slot_free} = 5'h00;
    {o_ad_addr, o_sb_addr, o_sb_hi_addr} = 96'h0;
    {o_ad_cmd, o_sb_cmd} = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One clock of drive; strobes are {ad, sideband, upper word, slot free}
  task automatic put(input logic [3:0] stb, input logic [31:0] a, input logic [3:0] c);
    @(posedge i_clk);
    #1;
    {o_ad_req, o_sb_req, o_sb_hi_req, o_slot_free} = stb;
    // Released lines flip, so a stale word never passes as fresh
    o_ad_addr = stb[3] ? a : ~o_ad_addr;
    o_ad_cmd = stb[3] ? c : ~o_ad_cmd;
    o_sb_addr = stb[2] ? a : ~o_sb_addr;
    o_sb_cmd = stb[2] ? c : ~o_sb_cmd;
    o_sb_hi_addr = stb[1] ? a : ~o_sb_hi_addr;
  endtask

  task automatic free();
    put(4'h1, 32'h0, 4'h0);
    outstanding--;
  endtask

  // A request the caller marks bad (reserved code) neither waits for nor counts a pipe slot
  task automatic send(input logic sb, input logic [3:0] cmd, input logic [31:0] addr,
                      input logic [31:0] hi, input logic bad);
    if (!bad && cmd != CMD_FENCE && outstanding >= SLOTS)
      free();
    if (sb != o_use_sideband)
    begin
      put(4'h0, 32'h0, 4'h0);
      o_use_sideband = sb;
    end
    if (sb && hi != hi_cur)
    begin
      put(4'h2, hi, 4'h0);
      hi_cur = hi;
    end
    if (sb)
      put(4'h4, addr, cmd);
    else if (hi != 32'h0)
    begin
      put(4'h8, addr, CMD_DAC);
      put(4'h8, hi, cmd);
    end
    else
      put(4'h8, addr, cmd);
    if (!bad && cmd != CMD_FENCE)
      outstanding++;
  endtask
endmodule // prd_master_model

// *** dv/prd_decoder_tb_top.sv ***
/*
  Self-checking bench for the request decoder: corner cases, reserved codes
  and a seeded random run, with expectations kept in a queue.
  Assumes the master model drives all request inputs.
*/
module prd_decoder_tb_top
  import prd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [63:0] addr;
    logic [5:0] units;
    logic [4:0] fl;
    logic [23:0] marks;
    int cyc;
  } prd_exp_s;

  logic clk, rst, diag_clear, use_sideband, ad_req, sb_req, sb_hi_req, slot_free;
  logic [31:0] ad_addr, sb_addr, sb_hi_addr;
  logic [3:0] ad_cmd, sb_cmd;
  logic req_valid, req_write, req_urgent, req_long, req_flush, req_fence;
  logic slot_overflow, reserved_seen;
  logic [63:0] req_addr;
  logic [5:0] req_units;
  logic [7:0] req_seq, req_wr_mark, req_rd_mark, reserved_count, fence_rd, rsv;
  logic [8:0] slots_used;
  logic [7:0] cnt [4];
  logic [31:0] seed, r;
  logic [3:0] legal [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hC};
  logic [3:0] bad [7] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
  prd_exp_s q [$];
  prd_exp_s e;
  int errors = 0;
  int checked = 0;
  int cyc = 0;

  prd_decoder #(.SLOTS(8)) i_prd_decoder (
    .i_clk(clk), .i_rst(rst), .i_use_sideband(use_sideband), .i_ad_req(ad_req),
    .i_ad_addr(ad_addr), .i_ad_cmd(ad_cmd), .i_sb_req(sb_req), .i_sb_addr(sb_addr),
    .i_sb_cmd(sb_cmd), .i_sb_hi_req(sb_hi_req), .i_sb_hi_addr(sb_hi_addr),
    .i_slot_free(slot_free), .i_diag_clear(diag_clear), .o_req_valid(req_valid),
    .o_req_addr(req_addr), .o_req_units(req_units), .o_req_write(req_write),
    .o_req_urgent(req_urgent), .o_req_long(req_long), .o_req_flush(req_flush),
    .o_req_fence(req_fence), .o_req_seq(req_seq), .o_req_wr_mark(req_wr_mark),
    .o_req_rd_mark(req_rd_mark), .o_slots_used(slots_used),
    .o_slot_overflow(slot_overflow), .o_reserved_seen(reserved_seen),
    .o_reserved_count(reserved_count));

  prd_master_model #(.SLOTS(8)) i_prd_master_model (
    .i_clk(clk), .o_use_sideband(use_sideband), .o_ad_req(ad_req),
    .o_ad_addr(ad_addr), .o_ad_cmd(ad_cmd), .o_sb_req(sb_req), .o_sb_addr(sb_addr),
    .o_sb_cmd(sb_cmd), .o_sb_hi_req(sb_hi_req), .o_sb_hi_addr(sb_hi_addr),
    .o_slot_free(slot_free));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [5:0] exp_units(input logic [3:0] c, input logic [2:0] len);
    if (c == CMD_FENCE)
      return 6'h00;
    if (c == CMD_FLUSH)
      return 6'h01;
    if (c[3])
      return ({3'h0, len} + 6'h01) << 2;
    return {3'h0, len} + 6'h01;
  endfunction

  // Flags as {write, urgent, long, flush, fence}
  function automatic logic [4:0] exp_flags(input logic [3:0] c);
    return {c[3:1] == 3'h2, c[0] && c != CMD_DAC, c[3:1] == 3'h4, c == CMD_FLUSH,
            c == CMD_FENCE};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) i_prd_master_model.put(4'h0, 32'h0, 4'h0);
  endtask

  task automatic send(input logic sb, input logic [3:0] c, input logic [2:0] len,
                      input logic [31:0] a, input logic [31:0] hi, input logic bd);
    logic [4:0] f;
    int s;
    i_prd_master_model.send(sb, c, {a[31:3], len}, hi, bd);
    if (bd)
    begin
      rsv++;
      return;
    end
    f = exp_flags(c);
    s = {f[3], f[4]};
    e.addr = (c == CMD_FLUSH || c == CMD_FENCE) ? 64'h0 : {hi, a[31:3], 3'h0};
    e.units = exp_units(c, len);
    e.fl = f;
    e.marks = {cnt[s], cnt[1], fence_rd};
    if (c == CMD_FENCE)
    begin
      e.marks[7:0] = cnt[0];
      fence_rd = cnt[0];
    end
    else
      cnt[s]++;
    e.cyc = cyc + 1;
    q.push_back(e);
  endtask

  task automatic final_report();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Valid must land exactly one clock after the taking edge
  always @(posedge clk)
  begin
    if (q.size() != 0 && q[0].cyc == cyc)
    begin
      e = q.pop_front();
      check(req_valid, 1'b1);
      check(req_addr, e.addr);
      check(req_units, e.units);
      check({req_write, req_urgent, req_long, req_flush, req_fence}, e.fl);
      check({req_seq, req_wr_mark, req_rd_mark}, e.marks);
    end
    else if (req_valid !== 1'b0)
      check(req_valid, 1'b0);
    cyc++;
  end

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #400000;
    errors++;
    final_report();
  end

  initial
  begin
    rst = 1'b1;
    diag_clear = 1'b0;
    seed = 32'hD103;
    rsv = 8'h00;
    fence_rd = 8'h00;
    foreach (cnt[i]) cnt[i] = 8'h00;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    check({req_valid, slots_used, reserved_count, slot_overflow, reserved_seen}, 64'h0);
    // Every legal code at both length bounds on the bus path and at lengths 3 and 7 on the sideband, back to back
    foreach (legal[i])
    begin
      send(1'b0, legal[i], 3'h7, 32'h100, 32'h0, 1'b0);
      send(1'b0, legal[i], 3'h0, 32'hFFFFFFF8, 32'hABC, 1'b0);
      send(1'b1, legal[i], 3'h3, 32'h48, 32'h0, 1'b0);
      send(1'b1, legal[i], 3'h7, 32'h8, 32'h7, 1'b0);
    end
    foreach (bad[i])
      send(i[0], bad[i], 3'h1, 32'h200, 32'h0, 1'b1);
    send(1'b1, CMD_DAC, 3'h2, 32'h300, 32'h0, 1'b1);
    send(1'b0, CMD_DAC, 3'h2, 32'h300, 32'h5, 1'b1);
    idle(2);
    check({reserved_seen, reserved_count}, {1'b1, rsv});
    diag_clear = 1'b1;
    idle(1);
    diag_clear = 1'b0;
    idle(2);
    check(reserved_seen, 1'b0);
    // Reserved code and clear on one edge: the new event must survive
    send(1'b0, bad[0], 3'h1, 32'h200, 32'h0, 1'b1);
    diag_clear = 1'b1;
    idle(1);
    diag_clear = 1'b0;
    check({reserved_seen, reserved_count}, {1'b1, rsv});
    // Seeded random traffic from the legal set
    repeat (300)
    begin
      r = xs();
      send(r[8], legal[r[2:0]], r[12:10], xs(), r[9] ? xs() : 32'h0, 1'b0);
    end
    send(1'b0, CMD_FLUSH, 3'h5, 32'h1238, 32'h0, 1'b0);
    idle(3);
    check(slots_used, i_prd_master_model.outstanding);
    while (i_prd_master_model.outstanding > 0)
      i_prd_master_model.free();
    idle(3);
    check({slots_used, slot_overflow}, 10'h000);
    // Overrun the eight slots on purpose; the ninth take must raise the flag
    repeat (9)
    begin
      i_prd_master_model.outstanding = 0;
      send(1'b0, CMD_READ, 3'h0, 32'h40, 32'h0, 1'b0);
    end
    idle(2);
    check({slots_used, slot_overflow}, {9'h009, 1'b1});
    i_prd_master_model.outstanding = 9;
    diag_clear = 1'b1;
    idle(1);
    diag_clear = 1'b0;
    while (i_prd_master_model.outstanding > 0)
      i_prd_master_model.free();
    idle(3);
    check({slots_used, slot_overflow}, 10'h000);
    check(q.size(), 0);
    final_report();
  end
endmodule // prd_decoder_tb_top
